//--- hdl/oag_params.svh
// Purpose: constants for the operand address generator
// Assumes: 8-bit register file, 16-bit memory addresses
// Notes: register locations are set-1 addresses
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH
`define OAG_SLICE0_ADDR 8'hD6
`define OAG_SLICE1_ADDR 8'hD7
`define OAG_SPH_ADDR 8'hD8
`define OAG_SPL_ADDR 8'hD9
`define OAG_SLICE0_RST 8'hC0
`define OAG_SLICE1_RST 8'hC8
`define OAG_WREG_NIBBLE 4'hC
`define OAG_SEL_BIT 3
`define OAG_PROT_LO 8'hC0
`endif

//--- hdl/oag_pkg.sv
// Purpose: types for the operand address generator
// Assumes: nothing beyond the params header
// Notes: mode codes are one-hot
package oag_pkg;
  typedef enum logic [6:0] {
    OAG_M_REG = 7'h01,
    OAG_M_PTR = 7'h02,
    OAG_M_IDXR = 7'h04,
    OAG_M_IDXM = 7'h08,
    OAG_M_DIR = 7'h10,
    OAG_M_VEC = 7'h20,
    OAG_M_PCO = 7'h40
  } oag_mode_e;
  typedef enum logic [5:0] {
    OAG_S_IDLE = 6'h01,
    OAG_S_PUSH_LO = 6'h02,
    OAG_S_PUSH_HI = 6'h04,
    OAG_S_PUSH_FL = 6'h08,
    OAG_S_POP_HI = 6'h10,
    OAG_S_POP_LO = 6'h20
  } oag_stk_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic we;
  } oag_rf_s;
endpackage

//--- hdl/oag_core.sv
// Purpose: operand, stack and branch address generation
// Assumes: decoder presents one request per cycle, pulses each stack request for one cycle only
// Notes: stack pointer has no reset value; protected flag marks illegal accesses
// Overview of operation
// - upper nibble 1100B marks a working-register reference, low nibble selects
// - bit 3 of address chooses slice pointer zero or one
// - final address is pointer bits 7:3 joined with operand bits 2:0
// - slice pointers at D6H, D7H; reset to C0H and C8H
// - register pair: high byte at even address, low byte at odd
// - call pushes program counter; subroutine_exit pops it, but only its high byte reaches pc_pop
// - interrupt pushes counter and flags; interrupt_exit pops both, loading flags_pop and only the counter high byte
// - pointer decrements before push, increments after pop
// - 16-bit stack pointer at D8H/D9H, undefined after reset
// - low byte wrap carries or borrows into high byte
// - user stacks via push/pull up/down anywhere in register file
// - indirect mode uses register content or pair content as address
// - indirect addressing may not reach C0H-FFH
// - indexed addressing may not reach C0H-FFH
// - short memory offset is sign-extended, -128 to +127
// - indexed register access adds instruction base to working register offset
// - indexed memory adds 8 or 16-bit offset to working pair base
// - register indexed only for register_move; memory moves index memory
// - direct mode takes 16-bit address; jump and call load counter
// - vector mode reads pair in lowest 256 program bytes
// - relative mode adds signed offset to next-instruction counter
// - branches and short_jump use relative addressing
`timescale 1ns/1ps
`include "oag_params.svh"
module oag_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [6:0] mode,
  input wire logic [7:0] opnd,
  input wire logic [15:0] opnd16,
  input wire logic [7:0] reg_val,
  input wire logic [15:0] pair_val,
  input wire logic [15:0] pc_val,
  input wire logic mem_access,
  input wire logic short_ofs,
  input wire logic is_reg_move,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic call_req,
  input wire logic sub_exit_req,
  input wire logic int_req,
  input wire logic int_exit_req,
  input wire logic [7:0] flags_val,
  input wire logic [7:0] stk_rdata,
  input wire logic ustk_req,
  input wire logic ustk_pop,
  input wire logic ustk_up,
  input wire logic [7:0] ustk_ptr,
  output logic [7:0] rf_addr,
  output logic [15:0] mem_addr,
  output logic [15:0] pc_next,
  output logic pc_load,
  output logic addr_fault,
  output logic [7:0] ustk_addr,
  output logic [7:0] ustk_ptr_new,
  output logic [7:0] cfg_rdata,
  output oag_pkg::oag_rf_s stk_bus,
  output logic [15:0] stk_addr,
  output logic [15:0] pc_pop,
  output logic [7:0] flags_pop,
  output logic stk_done
);
  // ************************************************************
  // slice pointers and stack pointer
  // ************************************************************
  logic [7:0] slice0_q, slice1_q, sph_q, spl_q;
  logic [15:0] sp_d;
  logic sp_we;
  oag_pkg::oag_stk_e st_q, st_d;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      slice0_q <= `OAG_SLICE0_RST;
      slice1_q <= `OAG_SLICE1_RST;
    end else if (cfg_we && cfg_addr == `OAG_SLICE0_ADDR) begin
      slice0_q <= cfg_wdata;
    end else if (cfg_we && cfg_addr == `OAG_SLICE1_ADDR) begin
      slice1_q <= cfg_wdata;
    end
  end

  // no reset: value is undefined until software loads it
  always_ff @(posedge mclk) begin
    if (sp_we) begin
      sph_q <= sp_d[15:8];
      spl_q <= sp_d[7:0];
    end else if (cfg_we && cfg_addr == `OAG_SPH_ADDR) begin
      sph_q <= cfg_wdata;
    end else if (cfg_we && cfg_addr == `OAG_SPL_ADDR) begin
      spl_q <= cfg_wdata;
    end
  end

  // ************************************************************
  // combinational address formation
  // ************************************************************
  function automatic logic [7:0] wreg_map(input logic [7:0] a, input logic [7:0] p0, input logic [7:0] p1);
    logic [7:0] p;
    p = a[`OAG_SEL_BIT] ? p1 : p0;
    if (a[7:4] == `OAG_WREG_NIBBLE) begin
      wreg_map = {p[7:3], a[2:0]};
    end else begin
      wreg_map = a;
    end
  endfunction

  function automatic logic prot(input logic [7:0] a);
    prot = a >= `OAG_PROT_LO;
  endfunction

  wire [15:0] sp_cur = {sph_q, spl_q};
  wire [7:0] wreg_addr = wreg_map(opnd, slice0_q, slice1_q);
  wire [7:0] idx_raddr = 8'(opnd + reg_val);
  wire [15:0] ofs_ext = short_ofs ? {{8{opnd[7]}}, opnd} : opnd16;
  wire [15:0] idx_maddr = 16'(pair_val + ofs_ext);
  wire [15:0] rel_addr = 16'(pc_val + {{8{opnd[7]}}, opnd});
  wire [15:0] vec_addr = {8'h00, opnd};
  wire ptr_fault = (mode == oag_pkg::OAG_M_PTR) && !mem_access && prot(reg_val);
  wire idx_fault = (mode == oag_pkg::OAG_M_IDXR) && (prot(idx_raddr) || !is_reg_move);

  logic [7:0] rf_d;
  logic [15:0] mem_d, pcn_d;
  logic pcl_d;
  always_comb begin
    rf_d = wreg_addr;
    mem_d = 16'h0000;
    pcn_d = pc_val;
    pcl_d = 1'b0;
    case (mode)
      oag_pkg::OAG_M_PTR: begin
        rf_d = reg_val;
        mem_d = pair_val;
      end
      oag_pkg::OAG_M_IDXR: rf_d = idx_raddr;
      oag_pkg::OAG_M_IDXM: mem_d = idx_maddr;
      oag_pkg::OAG_M_DIR: begin
        mem_d = opnd16;
        pcn_d = opnd16;
        pcl_d = !mem_access;
      end
      oag_pkg::OAG_M_VEC: mem_d = vec_addr;
      oag_pkg::OAG_M_PCO: begin
        pcn_d = rel_addr;
        pcl_d = 1'b1;
      end
      default: rf_d = wreg_addr;
    endcase
  end

  // user stacks: push down decrements before, pull up increments after
  wire [7:0] ustk_dec = 8'(ustk_ptr - 8'h01);
  wire [7:0] ustk_inc = 8'(ustk_ptr + 8'h01);
  // pushes store at the stepped pointer, pulls read the current one before stepping
  wire [7:0] unew_d = ustk_up ? ustk_inc : ustk_dec;
  wire [7:0] uaddr_d = ustk_pop ? ustk_ptr : unew_d;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rf_addr <= 8'h00;
      mem_addr <= 16'h0000;
      pc_next <= 16'h0000;
      pc_load <= 1'b0;
      addr_fault <= 1'b0;
      ustk_addr <= 8'h00;
      ustk_ptr_new <= 8'h00;
    end else begin
      rf_addr <= rf_d;
      mem_addr <= mem_d;
      pc_next <= pcn_d;
      pc_load <= pcl_d;
      addr_fault <= ptr_fault || idx_fault;
      ustk_addr <= ustk_req ? uaddr_d : ustk_addr;
      ustk_ptr_new <= ustk_req ? unew_d : ustk_ptr_new;
    end
  end

  // ************************************************************
  // system stack sequencer
  // ************************************************************
  // counter pushed low byte first so the high byte lands at the lower address, which is even only if SP starts even
  logic is_int_q, was_intx_q;
  logic [15:0] sp_dec, sp_inc;
  assign sp_dec = 16'(sp_cur - 16'h0001);
  assign sp_inc = 16'(sp_cur + 16'h0001);

  always_comb begin
    st_d = st_q;
    sp_we = 1'b0;
    sp_d = sp_cur;
    case (st_q)
      oag_pkg::OAG_S_IDLE: begin
        if (call_req || int_req) st_d = oag_pkg::OAG_S_PUSH_LO;
        else if (sub_exit_req || int_exit_req) st_d = int_exit_req ? oag_pkg::OAG_S_PUSH_FL : oag_pkg::OAG_S_POP_HI;
      end
      oag_pkg::OAG_S_PUSH_LO: begin
        sp_we = 1'b1;
        sp_d = sp_dec;
        st_d = oag_pkg::OAG_S_PUSH_HI;
      end
      oag_pkg::OAG_S_PUSH_HI: begin
        sp_we = 1'b1;
        sp_d = sp_dec;
        st_d = is_int_q ? oag_pkg::OAG_S_PUSH_FL : oag_pkg::OAG_S_IDLE;
      end
      oag_pkg::OAG_S_PUSH_FL: begin
        sp_we = 1'b1;
        sp_d = was_intx_q ? sp_inc : sp_dec;
        st_d = was_intx_q ? oag_pkg::OAG_S_POP_HI : oag_pkg::OAG_S_IDLE;
      end
      oag_pkg::OAG_S_POP_HI: begin
        sp_we = 1'b1;
        sp_d = sp_inc;
        st_d = oag_pkg::OAG_S_POP_LO;
      end
      oag_pkg::OAG_S_POP_LO: begin
        sp_we = 1'b1;
        sp_d = sp_inc;
        st_d = oag_pkg::OAG_S_IDLE;
      end
      default: st_d = oag_pkg::OAG_S_IDLE;
    endcase
  end

  // write cycles use the already-decremented address; pops read the top first
  wire [15:0] push_addr = sp_dec;
  wire push_st = (st_q == oag_pkg::OAG_S_PUSH_LO) || (st_q == oag_pkg::OAG_S_PUSH_HI) ||
                 ((st_q == oag_pkg::OAG_S_PUSH_FL) && !was_intx_q);
  wire [7:0] push_data = (st_q == oag_pkg::OAG_S_PUSH_LO) ? pc_val[7:0] :
                         (st_q == oag_pkg::OAG_S_PUSH_HI) ? pc_val[15:8] : flags_val;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= oag_pkg::OAG_S_IDLE;
      is_int_q <= 1'b0;
      was_intx_q <= 1'b0;
      stk_bus <= '0;
      stk_addr <= 16'h0000;
      pc_pop <= 16'h0000;
      flags_pop <= 8'h00;
      stk_done <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_q == oag_pkg::OAG_S_IDLE) begin
        is_int_q <= int_req;
        was_intx_q <= int_exit_req && !call_req && !int_req;
      end
      stk_bus.we <= push_st;
      stk_bus.addr <= push_st ? push_addr[7:0] : sp_cur[7:0];
      stk_bus.data <= push_data;
      stk_addr <= push_st ? push_addr : sp_cur;
      // stk_rdata is the byte at the address presented the previous cycle
      if (st_q == oag_pkg::OAG_S_POP_LO) pc_pop[15:8] <= stk_rdata;
      if (st_q == oag_pkg::OAG_S_IDLE && stk_done && !was_intx_q) pc_pop[7:0] <= pc_pop[7:0];
      if (st_q == oag_pkg::OAG_S_POP_HI && was_intx_q) flags_pop <= stk_rdata;
      stk_done <= (st_d == oag_pkg::OAG_S_IDLE) && (st_q != oag_pkg::OAG_S_IDLE);
    end
  end

  // ************************************************************
  // register reads
  // ************************************************************
  wire [7:0] rd_d = (cfg_addr == `OAG_SLICE0_ADDR) ? slice0_q :
                    (cfg_addr == `OAG_SLICE1_ADDR) ? slice1_q :
                    (cfg_addr == `OAG_SPH_ADDR) ? sph_q :
                    (cfg_addr == `OAG_SPL_ADDR) ? spl_q : 8'h00;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) cfg_rdata <= 8'h00;
    else cfg_rdata <= rd_d;
  end
endmodule // oag_core

//--- bench/oag_core_properties.sv
// Purpose: port-level checks of oag_core
// Assumes: one clock, outputs one cycle after inputs
// Notes: bind statement follows the module
`timescale 1ns/1ps
module oag_core_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [6:0] mode,
  input wire logic [7:0] opnd,
  input wire logic [7:0] reg_val,
  input wire logic [15:0] pair_val,
  input wire logic [15:0] pc_val,
  input wire logic mem_access,
  input wire logic short_ofs,
  input wire logic is_reg_move,
  input wire logic call_req,
  input wire logic [7:0] rf_addr,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] pc_next,
  input wire logic addr_fault,
  input wire oag_pkg::oag_rf_s stk_bus,
  input wire logic stk_done
);
  // ****
  // helpers
  // ****
  wire [15:0] sofs = {{8{opnd[7]}}, opnd};
  wire [7:0] isum = opnd + reg_val;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_wreg_low: assert property (mode == 7'h01 && opnd[7:4] == 4'hC |=> rf_addr[2:0] == $past(opnd[2:0]))
    else $error("working register low bits wrong");
  a_plain_reg: assert property (mode == 7'h01 && opnd[7:4] != 4'hC |=> rf_addr == $past(opnd))
    else $error("plain register address altered");
  a_ptr_guard: assert property (mode == 7'h02 && !mem_access && reg_val >= 8'hC0 |=> addr_fault)
    else $error("pointer access to protected area");
  a_idx_guard: assert property (mode == 7'h04 && isum >= 8'hC0 |=> addr_fault)
    else $error("indexed access to protected area");
  a_idx_move: assert property (mode == 7'h04 && !is_reg_move |=> addr_fault)
    else $error("indexed register without move");
  a_short_ofs: assert property (mode == 7'h08 && short_ofs |=> mem_addr == $past(pair_val + sofs))
    else $error("short offset not sign extended");
  a_vec_page: assert property (mode == 7'h20 |=> mem_addr == {8'h00, $past(opnd)})
    else $error("vector outside lowest page");
  a_rel_target: assert property (mode == 7'h40 |=> pc_next == $past(pc_val + sofs))
    else $error("relative target wrong");
  a_push_step: assert property (call_req |-> ##2 stk_bus.we ##1 (stk_bus.we && stk_bus.addr == $past(stk_bus.addr) - 8'h01))
    else $error("push address not stepping down");
  a_call_done: assert property (call_req |-> ##3 stk_done)
    else $error("call not done in time");
  c_call: cover property (call_req ##3 stk_done);
  c_fault: cover property (mode == 7'h04 ##1 addr_fault);
  c_wreg: cover property (mode == 7'h01 && opnd[7:4] == 4'hC);
endmodule // oag_core_chk
bind oag_core oag_core_chk i_chk (.mclk(mclk), .rst(rst), .mode(mode), .opnd(opnd), .reg_val(reg_val),
  .pair_val(pair_val), .pc_val(pc_val), .mem_access(mem_access), .short_ofs(short_ofs),
  .is_reg_move(is_reg_move), .call_req(call_req), .rf_addr(rf_addr), .mem_addr(mem_addr),
  .pc_next(pc_next), .addr_fault(addr_fault), .stk_bus(stk_bus), .stk_done(stk_done));

//--- bench/tb_top.sv
// Purpose: directed bench for oag_core
// Assumes: outputs settle one cycle after request
// Notes: pop data is not judged, only pointer arithmetic
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
  logic mclk = 0, rst = 1, mem_access = 0, short_ofs = 0, is_reg_move = 1, cfg_we = 0, call_req = 0;
  logic sub_exit_req = 0, int_req = 0, int_exit_req = 0, ustk_req = 0, ustk_pop = 0, ustk_up = 0, pc_load, addr_fault;
  logic stk_done;
  logic [6:0] mode = 7'h01;
  logic [7:0] opnd = 8'h00, reg_val = 8'h00, cfg_addr = 8'h00, cfg_wdata = 8'h00, flags_val = 8'h5A;
  logic [7:0] stk_rdata = 8'h00, ustk_ptr = 8'h40, rf_addr, ustk_addr, ustk_ptr_new, cfg_rdata, flags_pop;
  logic [15:0] opnd16 = 16'h0000, pair_val = 16'h0000, pc_val = 16'h0200, mem_addr, pc_next, stk_addr, pc_pop;
  oag_pkg::oag_rf_s stk_bus;
  int err_count = 0, total_checks = 0;
  oag_core i_dut (.mclk(mclk), .rst(rst), .mode(mode), .opnd(opnd), .opnd16(opnd16), .reg_val(reg_val),
    .pair_val(pair_val), .pc_val(pc_val), .mem_access(mem_access), .short_ofs(short_ofs),
    .is_reg_move(is_reg_move), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .call_req(call_req), .sub_exit_req(sub_exit_req), .int_req(int_req), .int_exit_req(int_exit_req),
    .flags_val(flags_val), .stk_rdata(stk_rdata), .ustk_req(ustk_req), .ustk_pop(ustk_pop), .ustk_up(ustk_up),
    .ustk_ptr(ustk_ptr), .rf_addr(rf_addr), .mem_addr(mem_addr), .pc_next(pc_next), .pc_load(pc_load),
    .addr_fault(addr_fault), .ustk_addr(ustk_addr), .ustk_ptr_new(ustk_ptr_new), .cfg_rdata(cfg_rdata),
    .stk_bus(stk_bus), .stk_addr(stk_addr), .pc_pop(pc_pop), .flags_pop(flags_pop), .stk_done(stk_done));
  always #50 mclk = ~mclk;
  // ****
  // bus tasks
  // ****
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    cfg_we <= 1'b1; cfg_addr <= a; cfg_wdata <= d;
    @(posedge mclk);
    cfg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    cfg_addr <= a;
    @(posedge mclk);
    #1 `CHK("cfg_rdata", e, cfg_rdata)
  endtask
  task automatic ask(input logic [6:0] m, input logic [7:0] o, input logic [7:0] r, input logic [15:0] p);
    @(posedge mclk);
    mode <= m; opnd <= o; reg_val <= r; pair_val <= p;
    @(posedge mclk);
    #1;
  endtask
  task automatic stk(input logic [3:0] k);
    @(posedge mclk);
    {call_req, sub_exit_req, int_req, int_exit_req} <= k;
    @(posedge mclk);
    {call_req, sub_exit_req, int_req, int_exit_req} <= 4'h0;
    for (int i = 0; i < 12 && stk_done !== 1'b1; i++) @(posedge mclk) #1;
    // a hung sequencer ends the run here rather than stalling later tests
    if (stk_done !== 1'b1) begin err_count++; $display("Error stk_done exp 1 got 0"); complete_run(); end
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_wreg();
    rd(8'hD6, 8'hC0);
    rd(8'hD7, 8'hC8);
    ask(7'h01, 8'hCB, 8'h00, 16'h0000); `CHK("rf_addr", 8'hCB, rf_addr)
    wr(8'hD6, 8'hA8);
    ask(7'h01, 8'hC3, 8'h00, 16'h0000); `CHK("rf_addr", 8'hAB, rf_addr)
    wr(8'hD7, 8'h70);
    ask(7'h01, 8'hCE, 8'h00, 16'h0000); `CHK("rf_addr", 8'h76, rf_addr)
    ask(7'h01, 8'h45, 8'h00, 16'h0000); `CHK("rf_addr", 8'h45, rf_addr)
    $display("test wreg done");
  endtask
  task automatic t_modes();
    ask(7'h02, 8'h00, 8'hC5, 16'h0000); `CHK("fault", 1'b1, addr_fault)
    ask(7'h02, 8'h00, 8'hBF, 16'h0000); `CHK("rf_addr", 8'hBF, rf_addr)
    ask(7'h04, 8'h10, 8'hB8, 16'h0000); `CHK("fault", 1'b1, addr_fault)
    ask(7'h04, 8'h10, 8'h20, 16'h0000); `CHK("rf_addr", 8'h30, rf_addr)
    is_reg_move <= 1'b0;
    ask(7'h04, 8'h10, 8'h20, 16'h0000); `CHK("fault", 1'b1, addr_fault)
    mem_access <= 1'b1; short_ofs <= 1'b1; opnd16 <= 16'h0234;
    ask(7'h08, 8'hF0, 8'h00, 16'h1000); `CHK("mem_addr", 16'h0FF0, mem_addr)
    short_ofs <= 1'b0;
    ask(7'h08, 8'hF0, 8'h00, 16'h1000); `CHK("mem_addr", 16'h1234, mem_addr)
    ask(7'h02, 8'h00, 8'h00, 16'hC0F0); `CHK("mem_addr", 16'hC0F0, mem_addr)
    ask(7'h10, 8'h00, 8'h00, 16'h0000); `CHK("pc_next", 16'h0234, pc_next)
    ask(7'h20, 8'h7E, 8'h00, 16'h0000); `CHK("mem_addr", 16'h007E, mem_addr)
    ask(7'h40, 8'h80, 8'h00, 16'h0000); `CHK("pc_next", 16'h0180, pc_next)
    ask(7'h40, 8'h7F, 8'h00, 16'h0000); `CHK("pc_next", 16'h027F, pc_next)
    `CHK("pc_load", 1'b1, pc_load)
    $display("test modes done");
  endtask
  task automatic t_stack();
    wr(8'hD8, 8'h12);
    wr(8'hD9, 8'h01);
    stk(4'h8);
    rd(8'hD9, 8'hFF);
    rd(8'hD8, 8'h11);
    `CHK("stk_addr", 16'h11FF, stk_addr)
    stk(4'h4);
    rd(8'hD9, 8'h01);
    rd(8'hD8, 8'h12);
    stk(4'h2);
    rd(8'hD9, 8'hFE);
    stk(4'h1);
    rd(8'hD9, 8'h01);
    wr(8'hD9, 8'hFF);
    stk(4'h8);
    rd(8'hD9, 8'hFD);
    rd(8'hD8, 8'h12);
    $display("test stack done");
  endtask
  task automatic t_ustk();
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      ustk_req <= 1'b1; {ustk_pop, ustk_up} <= i[1:0];
      @(posedge mclk);
      ustk_req <= 1'b0;
      #1 `CHK("ustk_ptr_new", (i[0] ? 8'h41 : 8'h3F), ustk_ptr_new)
      `CHK("ustk_addr", (i[1] ? 8'h40 : (i[0] ? 8'h41 : 8'h3F)), ustk_addr)
    end
    $display("test user stack done");
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_wreg();
    t_modes();
    t_stack();
    t_ustk();
    complete_run();
  end
endmodule // tb_top
